// ===== sppc_defs.svh
`ifndef SPPC_DEFS_SVH
`define SPPC_DEFS_SVH

// Bus bit positions shared by poll and status answers
`define SPPC_BIT_MODE      0
`define SPPC_BIT_ADDR_LO   1
`define SPPC_BIT_DCD       0
`define SPPC_BIT_TXAVAIL   3
`define SPPC_BIT_RING      4
`define SPPC_BIT_PARITY    5
`define SPPC_BIT_FRAMING   6
`define SPPC_BIT_OVERRUN   7

// Command decoder codes, bit order {a7, a6, a5, a0}
`define SPPC_CMD_MRESET    4'h2
`define SPPC_CMD_BREAK     4'h3

// Control flip-flop index carried in a0 and a5 of set/clear commands
`define SPPC_CTL_DTR       0
`define SPPC_CTL_RTS       1
`define SPPC_CTL_RX_ON     2
`define SPPC_CTL_TX_ON     3

// Reset values
`define SPPC_CTL_RST       4'h0
`define SPPC_BUS_RST       8'h00
`define SPPC_ERR_RST       3'h0

// Pulse widths in interface clocks
`define SPPC_DRR_CYCLES    1
`define SPPC_LOAD_CYCLES   1

`endif

// ===== sppc_pkg.sv
package sppc_pkg;

  typedef logic [7:0] sppc_byte_t;
  typedef logic [3:0] sppc_addr_t;
  typedef logic [3:0] sppc_code_t;

  typedef enum logic [2:0] {
    SPPC_OP_NONE,
    SPPC_OP_MRESET,
    SPPC_OP_BREAK,
    SPPC_OP_SET,
    SPPC_OP_CLEAR
  } sppc_op_t;

endpackage

// ===== sppc_sync3.sv
`timescale 1ns/1ps

module sppc_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  if (WIDTH < 1) begin : g_chk
    $error("sppc_sync3 needs WIDTH of at least one");
  end

  // A bit changes only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule

// ===== sppc_poll_io_control.sv
`timescale 1ns/1ps
`include "sppc_defs.svh"


module sppc_poll_io_control
  import sppc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire sppc_addr_t card_addr,
  input  wire logic       poll_in,
  input  wire logic       stat_cmd,
  input  wire logic       data_transfer_command,
  input  wire sppc_byte_t proc_addr_lines,
  input  wire logic       rx_data_ready,
  input  wire sppc_byte_t rx_char,
  input  wire logic       parity_fault,
  input  wire logic       framing_fault,
  input  wire logic       overrun_fault,
  input  wire logic       holding_reg_empty,
  input  wire logic       shift_reg_empty,
  input  wire logic       clear_to_send,
  input  wire logic       line_detect,
  input  wire logic       ring_indicator,
  input  wire logic       break_active,
  output sppc_byte_t      host_data_bus,
  output logic            host_data_bus_oe,
  output logic            poll_out,
  output logic            data_received_reset_n,
  output logic            holding_reg_load_n,
  output sppc_byte_t      tx_char,
  output sppc_byte_t      tx_shift_char,
  output logic            tx_shift_start,
  output logic            data_terminal_ready,
  output logic            request_to_send,
  output logic            receiver_disable,
  output logic            break_trigger,
  output logic            uart_reset
);

  // Pin synchronisers
  logic [8:0] pins_s;
  logic       dr_s;
  logic       holding_reg_empty_s;
  logic       tre_s;
  logic       cts_s;
  logic       dcd_s;
  logic       ring_s;
  logic       brk_s;
  logic [2:0] faults_s;

  sppc_sync3 #(
    .WIDTH (9)
  ) u_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in ({overrun_fault, framing_fault, parity_fault, break_active,
                ring_indicator, line_detect, clear_to_send, shift_reg_empty,
                holding_reg_empty}),
    .sync_out (pins_s)
  );

  assign holding_reg_empty_s   = pins_s[0];
  assign tre_s    = pins_s[1];
  assign cts_s    = pins_s[2];
  assign dcd_s    = pins_s[3];
  assign ring_s   = pins_s[4];
  assign brk_s    = pins_s[5];
  assign faults_s = pins_s[8:6];

  // Data-ready gets its own three-stage synchroniser so the receiver flags see it
  sppc_sync3 #(
    .WIDTH (1)
  ) u_sync_dr (
    .clock    (clock),
    .srst     (srst),
    .async_in (rx_data_ready),
    .sync_out (dr_s)
  );

  function automatic logic addr_match(input sppc_byte_t a, input sppc_addr_t strap);
    addr_match = (a[4:1] ~^ strap) == 4'hF;
  endfunction

  function automatic sppc_op_t decode_op(input sppc_code_t code);
    if (code[3]) begin
      decode_op = code[2] ? SPPC_OP_CLEAR : SPPC_OP_SET;
    end else if (code == `SPPC_CMD_MRESET) begin
      decode_op = SPPC_OP_MRESET;
    end else if (code == `SPPC_CMD_BREAK) begin
      decode_op = SPPC_OP_BREAK;
    end else begin
      decode_op = SPPC_OP_NONE;
    end
  endfunction

  // Control flip-flops and command decoder
  logic [3:0] ctl_reg;
  logic [3:0] ctl_next;
  sppc_code_t code_reg;
  sppc_code_t code_next;
  logic       code_valid_reg;
  logic       code_valid_next;
  logic       brk_trig_reg;
  logic       brk_trig_next;
  logic       mreset_reg;
  logic       mreset_next;
  sppc_op_t   op;
  logic       stat_hit;
  logic [1:0] ctl_idx;

  assign stat_hit = stat_cmd && addr_match(proc_addr_lines, card_addr);
  assign op       = code_valid_reg ? decode_op(code_reg) : SPPC_OP_NONE;
  assign ctl_idx  = {code_reg[1], code_reg[0]};

  always_comb begin
    ctl_next        = ctl_reg;
    code_next       = code_reg;
    code_valid_next = 1'b0;
    brk_trig_next   = 1'b0;
    mreset_next     = 1'b0;
    if (stat_hit) begin
      code_next       = {proc_addr_lines[7:5], proc_addr_lines[0]};
      code_valid_next = 1'b1;
    end
    unique case (op)
      SPPC_OP_MRESET: begin
        ctl_next    = `SPPC_CTL_RST;
        mreset_next = 1'b1;
      end
      SPPC_OP_BREAK: brk_trig_next = 1'b1;
      SPPC_OP_SET:   ctl_next[ctl_idx] = 1'b1;
      SPPC_OP_CLEAR: ctl_next[ctl_idx] = 1'b0;
      SPPC_OP_NONE:  ctl_next = ctl_reg;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctl_reg        <= `SPPC_CTL_RST;
      code_reg       <= 4'h0;
      code_valid_reg <= 1'b0;
      brk_trig_reg   <= 1'b0;
      mreset_reg     <= 1'b0;
    end else begin
      ctl_reg        <= ctl_next;
      code_reg       <= code_next;
      code_valid_reg <= code_valid_next;
      brk_trig_reg   <= brk_trig_next;
      mreset_reg     <= mreset_next;
    end
  end

  // Ready and select flags
  logic rx_ready_reg;
  logic rx_ready_next;
  logic rx_sel_reg;
  logic rx_sel_next;
  logic tx_ready_reg;
  logic tx_ready_next;
  logic tx_sel_reg;
  logic tx_sel_next;
  logic tx_ready_eff;
  logic rx_on;
  logic tx_on;
  logic poll_rx;
  logic poll_tx;
  logic xfer_rx;
  logic xfer_tx;
  logic kill;

  assign rx_on   = ctl_reg[`SPPC_CTL_RX_ON];
  assign tx_on   = ctl_reg[`SPPC_CTL_TX_ON];
  assign kill    = (op == SPPC_OP_MRESET);
  // Gated without a clock so turning off or a break wins at once
  assign tx_ready_eff = tx_ready_reg && tx_on && !brk_s;
  assign poll_rx = poll_in && rx_ready_reg;
  assign poll_tx = poll_in && !rx_ready_reg && tx_ready_eff;
  assign xfer_rx = data_transfer_command && rx_sel_reg;
  assign xfer_tx = data_transfer_command && tx_sel_reg && !rx_sel_reg;

  always_comb begin
    rx_ready_next = rx_on && dr_s;
    rx_sel_next   = rx_sel_reg || poll_rx;
    if (!rx_on || !dr_s) begin
      rx_sel_next = 1'b0;
    end
    tx_ready_next = tx_on && !brk_s && cts_s && holding_reg_empty_s;
    tx_sel_next   = (tx_sel_reg || poll_tx) && !xfer_tx;
    if (!tx_ready_eff) begin
      tx_sel_next = 1'b0;
    end
    if (kill) begin
      rx_ready_next = 1'b0;
      rx_sel_next   = 1'b0;
      tx_ready_next = 1'b0;
      tx_sel_next   = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_ready_reg <= 1'b0;
      rx_sel_reg   <= 1'b0;
      tx_ready_reg <= 1'b0;
      tx_sel_reg   <= 1'b0;
    end else begin
      rx_ready_reg <= rx_ready_next;
      rx_sel_reg   <= rx_sel_next;
      tx_ready_reg <= tx_ready_next;
      tx_sel_reg   <= tx_sel_next;
    end
  end

  // Error latch loads as the receiver drops its ready flag
  logic [2:0] err_reg;
  logic [2:0] err_next;

  always_comb begin
    err_next = err_reg;
    if (rx_ready_reg && !rx_ready_next) begin
      err_next = faults_s;
    end
    if (kill) begin
      err_next = `SPPC_ERR_RST;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      err_reg <= `SPPC_ERR_RST;
    end else begin
      err_reg <= err_next;
    end
  end

  // Data bus answers, registered so the bus comes from flip-flops
  sppc_byte_t bus_reg;
  sppc_byte_t bus_next;
  logic       bus_oe_reg;
  logic       bus_oe_next;
  logic       poll_out_reg;
  logic       poll_out_next;

  always_comb begin
    bus_next      = `SPPC_BUS_RST;
    bus_oe_next   = 1'b0;
    poll_out_next = poll_in && !rx_ready_reg && !tx_ready_eff;
    if (xfer_rx) begin
      bus_next    = rx_char;
      bus_oe_next = 1'b1;
    end else if (poll_rx || poll_tx) begin
      bus_next[`SPPC_BIT_ADDR_LO +: 4] = card_addr;
      bus_next[`SPPC_BIT_MODE]         = poll_rx;
      bus_next[7:5]                    = err_reg;
      bus_oe_next                      = 1'b1;
    end else if (stat_hit) begin
      bus_next[`SPPC_BIT_DCD]     = dcd_s;
      bus_next[`SPPC_BIT_TXAVAIL] = cts_s && holding_reg_empty_s && tre_s;
      bus_next[`SPPC_BIT_RING]    = ring_s;
      bus_next[7:5]               = err_reg;
      bus_oe_next                 = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bus_reg      <= `SPPC_BUS_RST;
      bus_oe_reg   <= 1'b0;
      poll_out_reg <= 1'b0;
    end else begin
      bus_reg      <= bus_next;
      bus_oe_reg   <= bus_oe_next;
      poll_out_reg <= poll_out_next;
    end
  end

  // Strobes to the receiver-transmitter and the transmit staging
  logic       drr_n_reg;
  logic       drr_n_next;
  logic       load_n_reg;
  logic       load_n_next;
  sppc_byte_t tx_char_reg;
  sppc_byte_t tx_char_next;
  sppc_byte_t shift_char_reg;
  sppc_byte_t shift_char_next;
  logic       shift_start_reg;
  logic       shift_start_next;
  logic       pend_reg;
  logic       pend_next;

  always_comb begin
    drr_n_next       = !xfer_rx;
    load_n_next      = !xfer_tx;
    tx_char_next     = xfer_tx ? proc_addr_lines : tx_char_reg;
    shift_char_next  = shift_char_reg;
    shift_start_next = 1'b0;
    pend_next        = pend_reg || (!load_n_reg && load_n_next);
    // Waiting for the shifter keeps the character in the holding stage
    if (pend_next && tre_s && !shift_start_reg) begin
      shift_char_next  = tx_char_reg;
      shift_start_next = 1'b1;
      pend_next        = 1'b0;
    end
    if (kill) begin
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      drr_n_reg       <= 1'b1;
      load_n_reg      <= 1'b1;
      tx_char_reg     <= `SPPC_BUS_RST;
      shift_char_reg  <= `SPPC_BUS_RST;
      shift_start_reg <= 1'b0;
      pend_reg        <= 1'b0;
    end else begin
      drr_n_reg       <= drr_n_next;
      load_n_reg      <= load_n_next;
      tx_char_reg     <= tx_char_next;
      shift_char_reg  <= shift_char_next;
      shift_start_reg <= shift_start_next;
      pend_reg        <= pend_next;
    end
  end

  assign host_data_bus         = bus_reg;
  assign host_data_bus_oe      = bus_oe_reg;
  assign poll_out              = poll_out_reg;
  assign data_received_reset_n = drr_n_reg;
  assign holding_reg_load_n    = load_n_reg;
  assign tx_char               = tx_char_reg;
  assign tx_shift_char         = shift_char_reg;
  assign tx_shift_start        = shift_start_reg;
  assign data_terminal_ready   = ctl_reg[`SPPC_CTL_DTR];
  assign request_to_send       = ctl_reg[`SPPC_CTL_RTS];
  assign receiver_disable      = ~ctl_reg[`SPPC_CTL_RX_ON];
  assign break_trigger         = brk_trig_reg;
  assign uart_reset            = mreset_reg;

endmodule

// ===== sppc_uart_model.sv
`timescale 1ns/1ps

module sppc_uart_model (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic rx_push,
  input  wire logic data_received_reset_n,
  input  wire logic holding_reg_load_n,
  input  wire logic tx_shift_start,
  output logic      rx_data_ready,
  output logic      holding_reg_empty,
  output logic      shift_reg_empty
);
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_data_ready     <= 1'b0;
      holding_reg_empty <= 1'b1;
    end else begin
      if (rx_push) rx_data_ready <= 1'b1;
      if (!data_received_reset_n) rx_data_ready <= 1'b0;
      if (!holding_reg_load_n) holding_reg_empty <= 1'b0;
      if (tx_shift_start) holding_reg_empty <= 1'b1;
    end
  end
  // Shifter always idle: the wait-for-shifter path stays unexercised
  assign shift_reg_empty = 1'b1;
endmodule

// ===== sppc_poll_io_control_properties.sv
`timescale 1ns/1ps

module sppc_poll_io_control_chk
  import sppc_pkg::*;
(
  input wire logic       clock,
  input wire logic       srst,
  input wire sppc_addr_t card_addr,
  input wire logic       poll_in,
  input wire logic       stat_cmd,
  input wire logic       data_transfer_command,
  input wire sppc_byte_t proc_addr_lines,
  input wire sppc_byte_t rx_char,
  input wire sppc_byte_t host_data_bus,
  input wire logic       host_data_bus_oe,
  input wire logic       poll_out,
  input wire logic       data_received_reset_n,
  input wire logic       holding_reg_load_n,
  input wire sppc_byte_t tx_char,
  input wire logic       data_terminal_ready,
  input wire logic       request_to_send,
  input wire logic       receiver_disable,
  input wire logic       uart_reset
);
  logic m;
  logic p;
  assign m = stat_cmd && proc_addr_lines[4:1] == card_addr;
  assign p = poll_in && !stat_cmd && !data_transfer_command;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_stat_match: assert property (
    m |=> host_data_bus_oe && host_data_bus[2:1] == 2'b00) else $error("status not answered");
  a_stat_mismatch: assert property (
    stat_cmd && !m && !poll_in && !data_transfer_command |=> !host_data_bus_oe)
    else $error("bus driven on mismatch");
  a_poll_refuse: assert property (
    p |=> host_data_bus_oe != poll_out) else $error("poll answer and pass-on clash");
  a_poll_addr: assert property (
    p |=> !host_data_bus_oe || host_data_bus[4:1] == card_addr) else $error("poll address");
  // Three cycles so a flag cleared one clock late is not blamed
  a_rx_off: assert property (
    receiver_disable && $past(receiver_disable) && $past(receiver_disable, 2) && p
    |=> !(host_data_bus_oe && host_data_bus[0])) else $error("receive mode while off");
  a_drr_pulse: assert property (
    !data_received_reset_n |-> host_data_bus_oe && host_data_bus == $past(rx_char)
    ##1 data_received_reset_n) else $error("receive transfer");
  a_load_pulse: assert property (
    !holding_reg_load_n |-> tx_char == $past(proc_addr_lines) ##1 holding_reg_load_n)
    else $error("holding load");
  a_ctl_set: assert property (
    m && proc_addr_lines[7:5] == 3'b100 && !proc_addr_lines[0] |-> ##2 data_terminal_ready)
    else $error("set not applied");
  a_ctl_clear: assert property (
    m && proc_addr_lines[7:5] == 3'b110 && !proc_addr_lines[0] |-> ##2 !data_terminal_ready)
    else $error("clear not applied");
  a_plain_read: assert property (
    m && proc_addr_lines[7:5] == 3'b000 |-> ##2 $stable(request_to_send))
    else $error("plain read changed state");
  a_master_reset: assert property (
    uart_reset |-> !data_terminal_ready && !request_to_send && receiver_disable)
    else $error("master reset left flags on");
endmodule

bind sppc_poll_io_control sppc_poll_io_control_chk u_chk (.clock, .srst, .card_addr,
  .poll_in, .stat_cmd, .data_transfer_command, .proc_addr_lines, .rx_char, .host_data_bus,
  .host_data_bus_oe, .poll_out, .data_received_reset_n, .holding_reg_load_n, .tx_char,
  .data_terminal_ready, .request_to_send, .receiver_disable, .uart_reset);

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end

module tb
  import sppc_pkg::*;
;
  logic clock = 1'b0, srst = 1'b1, poll_in = 1'b0, stat_cmd = 1'b0, rx_push = 1'b0;
  logic data_transfer_command = 1'b0, line_detect = 1'b0, ring_indicator = 1'b0;
  logic clear_to_send = 1'b0, break_active = 1'b0;
  logic parity_fault = 1'b0, framing_fault = 1'b0, overrun_fault = 1'b0;
  sppc_addr_t card_addr;
  sppc_byte_t proc_addr_lines = 8'h00, rx_char, host_data_bus, tx_char, tx_shift_char, b;
  logic host_data_bus_oe, poll_out, data_received_reset_n, holding_reg_load_n;
  logic tx_shift_start, data_terminal_ready, request_to_send, receiver_disable;
  logic break_trigger, uart_reset, rx_data_ready, holding_reg_empty, shift_reg_empty;
  logic [31:0] seed = 32'h0001_6f15;
  logic [3:0]  ctl = 4'h0;
  logic        oe_s, pout_s, drr_s, load_s;
  sppc_byte_t  bus_s;
  int          num_errors = 0, checks = 0, cyc = 0;

  sppc_poll_io_control uut (.clock, .srst, .card_addr, .poll_in, .stat_cmd,
    .data_transfer_command, .proc_addr_lines, .rx_data_ready, .rx_char, .parity_fault,
    .framing_fault, .overrun_fault, .holding_reg_empty, .shift_reg_empty, .clear_to_send,
    .line_detect, .ring_indicator, .break_active, .host_data_bus, .host_data_bus_oe,
    .poll_out, .data_received_reset_n, .holding_reg_load_n, .tx_char, .tx_shift_char,
    .tx_shift_start, .data_terminal_ready, .request_to_send, .receiver_disable,
    .break_trigger, .uart_reset);
  sppc_uart_model u_far (.clock, .srst, .rx_push, .data_received_reset_n,
    .holding_reg_load_n, .tx_shift_start, .rx_data_ready, .holding_reg_empty,
    .shift_reg_empty);

  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [3:0] exp_ctl(logic [3:0] c, logic [3:0] k);
    if (k == 4'h2) return 4'h0;
    if (k[3]) c[{k[1], k[0]}] = ~k[2];
    return c;
  endfunction

  task wt(int n);
    repeat (n) @(negedge clock);
  endtask
  // Commands spaced three clocks so each decode lands alone
  // Answers stand one clock only, so they are caught mid-task
  task op(logic s, logic p, logic d, sppc_byte_t a);
    @(negedge clock);
    stat_cmd = s;
    poll_in = p;
    data_transfer_command = d;
    proc_addr_lines = a;
    @(negedge clock);
    oe_s = host_data_bus_oe;
    pout_s = poll_out;
    drr_s = data_received_reset_n;
    load_s = holding_reg_load_n;
    bus_s = host_data_bus;
    stat_cmd = 1'b0;
    poll_in = 1'b0;
    data_transfer_command = 1'b0;
    @(negedge clock);
  endtask
  task cmd(logic [3:0] k);
    op(1'b1, 1'b0, 1'b0, {k[3:1], card_addr, k[0]});
    `CHK(oe_s, 1'b1);
    `CHK(break_trigger, k == 4'h3);
    `CHK(uart_reset, k == 4'h2);
    ctl = exp_ctl(ctl, k);
    wt(1);
    `CHK({~receiver_disable, request_to_send, data_terminal_ready}, ctl[2:0]);
  endtask
  task rx_char_arrives();
    rx_push = 1'b1;
    wt(1);
    rx_push = 1'b0;
    wt(6);
  endtask
  task wrap_up();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    card_addr = sppc_addr_t'(rnd());
    rx_char = sppc_byte_t'(rnd());
    wt(10);
    srst = 1'b0;
    `CHK({host_data_bus_oe, poll_out, receiver_disable, data_terminal_ready}, 4'h2);
    for (int k = 0; k < 16; k++) cmd(k[3:0]);
    op(1'b1, 1'b0, 1'b0, {3'b100, card_addr ^ 4'h8, 1'b0});
    `CHK(oe_s, 1'b0);
    wt(1);
    `CHK(data_terminal_ready, 1'b0);
    $display("test decoder done");
    repeat (4) begin
      b = sppc_byte_t'(rnd());
      line_detect = b[0];
      ring_indicator = b[1];
      clear_to_send = b[2];
      wt(6);
      op(1'b1, 1'b0, 1'b0, {3'b000, card_addr, b[3]});
      `CHK(bus_s, {3'b000, b[1], b[2] & holding_reg_empty, 2'b00, b[0]});
    end
    $display("test status done");
    clear_to_send = 1'b1;
    cmd(4'ha);
    rx_char_arrives();
    op(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK({oe_s, bus_s}, {1'b1, 3'b000, card_addr, 1'b1});
    op(1'b0, 1'b0, 1'b1, 8'h00);
    `CHK({oe_s, drr_s, bus_s}, {2'b10, rx_char});
    wt(8);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK({oe_s, pout_s}, 2'b01);
    rx_char_arrives();
    cmd(4'he);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK({oe_s, pout_s}, 2'b01);
    $display("test receive done");
    cmd(4'hb);
    wt(6);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK({oe_s, bus_s}, {1'b1, 3'b000, card_addr, 1'b0});
    b = sppc_byte_t'(rnd());
    op(1'b0, 1'b0, 1'b1, b);
    `CHK({load_s, tx_char}, {1'b0, b});
    wt(4);
    `CHK(tx_shift_char, b);
    cmd(4'hf);
    op(1'b0, 1'b1, 1'b0, 8'h00);
    `CHK(pout_s, 1'b1);
    $display("test transmit done");
    wrap_up();
  end
endmodule
